// [common/rbcd_map.svh]
`ifndef RBCD_MAP_SVH
`define RBCD_MAP_SVH
// ASCII codes
`define RBCD_CH_CR     8'h0d
`define RBCD_CH_LF     8'h0a
`define RBCD_CH_COMMA  8'h2c
`define RBCD_CH_L      8'h4c
`define RBCD_CH_V      8'h56
`define RBCD_CH_I      8'h49
`define RBCD_CH_E      8'h45
`define RBCD_CH_PLUS   8'h2b
`define RBCD_CH_MINUS  8'h2d
`define RBCD_CH_DOT    8'h2e
`define RBCD_CH_ZERO   8'h30
`define RBCD_CH_TWO    8'h32
// Interface message codes (ATN true, low seven bits)
`define RBCD_MSG_GTL   7'h01
`define RBCD_MSG_UNL   7'h3f
`define RBCD_MSG_UNT   7'h5f
`define RBCD_GRP_LAG   2'h1
`define RBCD_GRP_TAG   2'h2
`define RBCD_GRP_ACG   2'h0
// Field positions and sizes
`define RBCD_ADDR_W    5
`define RBCD_VRNG_MAX  4'h2
`define RBCD_IRNG_MAX  4'h5
`define RBCD_VRNG_RST  2'h0
`define RBCD_IRNG_RST  3'h0
// Response: sign, digit, point, four digits, E, sign, exponent, CR, LF
`define RBCD_RESP_LEN  4'hc
`define RBCD_RESP_LAST 4'hb
// Reading rate in milli-readings per second (2.5 per second)
`define RBCD_RATE_MRPS 2500
`define RBCD_CLK_HZ    20000000
`endif

// [common/rbcd_pkg.sv]
package rbcd_pkg;
  typedef enum logic [1:0]
  {
    RBCD_LOCAL  = 2'h0,
    RBCD_REMOTE = 2'h1
  } rbcd_rem_t;
  typedef enum logic [1:0]
  {
    RBCD_CMD_IDLE = 2'h0,
    RBCD_CMD_VDIG = 2'h1,
    RBCD_CMD_IDIG = 2'h3,
    RBCD_CMD_SKIP = 2'h2
  } rbcd_cmd_t;
endpackage : rbcd_pkg

// [core/rbcd_rate_div.sv]
`timescale 1ns/100ps
`include "rbcd_map.svh"
module rbcd_rate_div #(
  parameter int unsigned PERIOD_CYC = 8000000
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  output logic      tick_o
);
  localparam int unsigned CW = $clog2(PERIOD_CYC + 1);
  logic [CW-1:0] cnt_ff;
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end
    else if (cnt_ff == CW'(PERIOD_CYC - 1))
    begin
      cnt_ff <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + CW'(1);
      tick_o <= 1'b0;
    end
  end
endmodule : rbcd_rate_div

// [core/rbcd_decoder.sv]
`timescale 1ns/100ps
`include "rbcd_map.svh"
// Functional notes
// RULE_01: Bus address is weighted sum of five switches, weights 1 to 16.
// RULE_02: Switch address captured once after power-up only.
// RULE_03: Installer should avoid addresses 0 and 31.
// RULE_04: After power-up start local with remote lamp dark.
// RULE_05: In local, discard device commands; front panel stays enabled.
// RULE_06: Return-to-local message addressed to us forces local.
// RULE_07: Character L as device command forces local.
// RULE_08: Remote entered only on own listen address while REN asserted.
// RULE_09: Remote lights lamp and disables panel except power.
// RULE_10: Talk-addressed device returns reading without query, local or remote.
// RULE_11: Reading empties buffer; refilled only after next conversion.
// RULE_12: New readings offered at two and a half per second.
// RULE_13: Reading formatted as signed mantissa, point, E, signed exponent. The code always sends a plus sign for the mantissa.
// RULE_14: Over-range reports fixed string plus two point zero mantissa.
// RULE_15: Every response ends with CR then LF.
// RULE_16: Line ends on CR or EOI with last byte.
// RULE_17: Controller sends upper-case command letters only.
// RULE_18: Comma-separated commands executed in turn.
// RULE_19: V digit 0,1,2 selects 20 mV, 200 mV, 2 V.
// RULE_20: I digit 0 to 5 selects 0.1 mA up to 10 A.
// RULE_21: ATN true bytes are interface messages, else device commands.
// RULE_22: Addressed group only when addressed; universal always; no secondaries.
// RULE_23: Bus lines are low-true.
// RULE_24: Controller asserts ATN with addresses and interface commands.
// RULE_25: Talker holds handshake off while buffer empty.
module rbcd_decoder #(
  parameter int unsigned CLK_HZ = `RBCD_CLK_HZ
) (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [4:0] addr_sw_i,
  // Bus pins, low-true levels
  input  wire logic [7:0] dio_n_i,
  input  wire logic       atn_n_i,
  input  wire logic       eoi_n_i,
  input  wire logic       ren_n_i,
  input  wire logic       dav_n_i,
  input  wire logic       nrfd_n_i,
  input  wire logic       ndac_n_i,
  output logic [7:0]      dio_n_o,
  output logic            dio_oe_n_o,
  output logic            eoi_n_o,
  output logic            eoi_oe_n_o,
  output logic            dav_n_o,
  output logic            dav_oe_n_o,
  output logic            nrfd_n_o,
  output logic            nrfd_oe_n_o,
  output logic            ndac_n_o,
  output logic            ndac_oe_n_o,
  // Converter result
  input  wire logic       conv_vld_i,
  input  wire logic       conv_ovr_i,
  input  wire logic [3:0] conv_dig_i [5],
  input  wire logic       conv_exp_neg_i,
  input  wire logic [3:0] conv_exp_i,
  // Instrument state
  output logic            remote_led_o,
  output logic            panel_en_o,
  output logic [1:0]      vrange_o,
  output logic [2:0]      irange_o,
  output logic [4:0]      bus_addr_o
);
  localparam int unsigned RATE_CYC = (CLK_HZ / `RBCD_RATE_MRPS) * 1000;

  logic        tick;
  logic        addr_cap_ff;
  logic        lstn_ff;
  logic        talk_ff;
  logic        buf_full_ff;
  logic        conv_pend_ff;
  logic [7:0]  resp_ff [`RBCD_RESP_LEN];
  logic [3:0]  tx_idx_ff;
  logic [1:0]  tx_st_ff;
  logic [1:0]  rx_st_ff;
  rbcd_pkg::rbcd_rem_t rem_ff;
  rbcd_pkg::rbcd_cmd_t cmd_ff;

  // Bus levels, true when asserted
  logic [7:0] dio;
  logic       atn;
  logic       eoi;
  logic       dav;
  logic       ren;
  logic       rx_take;
  logic       dd_byte;
  logic       line_end;
  assign dio = ~dio_n_i;                                   // RULE_23
  assign atn = ~atn_n_i;
  assign eoi = ~eoi_n_i;
  assign dav = ~dav_n_i;
  assign ren = ~ren_n_i;
  assign rx_take  = dav && (rx_st_ff == 2'h0);
  assign dd_byte  = rx_take && !atn && lstn_ff;            // RULE_21
  assign line_end = dd_byte && (eoi || dio == `RBCD_CH_CR); // RULE_16

  rbcd_rate_div #(
    .PERIOD_CYC (RATE_CYC)
  ) u_rate (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .tick_o    (tick)
  );

  // ----------------------------------------
  // Address capture
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      addr_cap_ff <= 1'b0;
      bus_addr_o  <= 5'h00;
    end
    else if (!addr_cap_ff)
    begin
      addr_cap_ff <= 1'b1;
      bus_addr_o  <= addr_sw_i;                            // RULE_01 RULE_02
    end
  end

  // ----------------------------------------
  // Listener handshake and addressing
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      rx_st_ff <= 2'h0;
    end
    else if (rx_take)
    begin
      rx_st_ff <= 2'h1;
    end
    else if (!dav)
    begin
      rx_st_ff <= 2'h0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      lstn_ff <= 1'b0;
      talk_ff <= 1'b0;
    end
    else if (rx_take && atn)
    begin
      if (dio[6:0] == `RBCD_MSG_UNL)
        lstn_ff <= 1'b0;
      else if (dio[6:5] == `RBCD_GRP_LAG && dio[4:0] == bus_addr_o)
        lstn_ff <= 1'b1;
      if (dio[6:0] == `RBCD_MSG_UNT)
        talk_ff <= 1'b0;
      else if (dio[6:5] == `RBCD_GRP_TAG)
        talk_ff <= (dio[4:0] == bus_addr_o);
    end
  end

  // ----------------------------------------
  // Local and remote
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      rem_ff <= rbcd_pkg::RBCD_LOCAL;                      // RULE_04
    end
    else if (rx_take && atn)
    begin
      case (rem_ff)
        rbcd_pkg::RBCD_LOCAL:
          if (ren && dio[6:5] == `RBCD_GRP_LAG && dio[4:0] == bus_addr_o)
            rem_ff <= rbcd_pkg::RBCD_REMOTE;               // RULE_08
        rbcd_pkg::RBCD_REMOTE:
          if (dio[6:0] == `RBCD_MSG_GTL && lstn_ff)        // RULE_22
            rem_ff <= rbcd_pkg::RBCD_LOCAL;                // RULE_06
        default:
          rem_ff <= rbcd_pkg::RBCD_LOCAL;
      endcase
    end
    else if (dd_byte && dio == `RBCD_CH_L && rem_ff == rbcd_pkg::RBCD_REMOTE)
    begin
      rem_ff <= rbcd_pkg::RBCD_LOCAL;                      // RULE_07
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      remote_led_o <= 1'b0;
      panel_en_o   <= 1'b1;
    end
    else
    begin
      remote_led_o <= (rem_ff == rbcd_pkg::RBCD_REMOTE);  // RULE_09
      panel_en_o   <= (rem_ff != rbcd_pkg::RBCD_REMOTE);  // RULE_05
    end
  end

  // ----------------------------------------
  // Device command parser
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      cmd_ff   <= rbcd_pkg::RBCD_CMD_IDLE;
      vrange_o <= `RBCD_VRNG_RST;
      irange_o <= `RBCD_IRNG_RST;
    end
    else if (dd_byte)
    begin
      if (dio == `RBCD_CH_COMMA || dio == `RBCD_CH_CR)
        cmd_ff <= rbcd_pkg::RBCD_CMD_IDLE;                 // RULE_18
      else if (rem_ff == rbcd_pkg::RBCD_REMOTE)            // RULE_05
      begin
      case (cmd_ff)
        rbcd_pkg::RBCD_CMD_IDLE:
          if (dio == `RBCD_CH_V)
            cmd_ff <= rbcd_pkg::RBCD_CMD_VDIG;
          else if (dio == `RBCD_CH_I)
            cmd_ff <= rbcd_pkg::RBCD_CMD_IDIG;
          else
            cmd_ff <= rbcd_pkg::RBCD_CMD_SKIP;
        rbcd_pkg::RBCD_CMD_VDIG:
        begin
          if (dio[7:4] == `RBCD_CH_ZERO >> 4 && dio[3:0] <= `RBCD_VRNG_MAX)
            vrange_o <= dio[1:0];                          // RULE_19
          cmd_ff <= rbcd_pkg::RBCD_CMD_SKIP;
        end
        rbcd_pkg::RBCD_CMD_IDIG:
        begin
          if (dio[7:4] == `RBCD_CH_ZERO >> 4 && dio[3:0] <= `RBCD_IRNG_MAX)
            irange_o <= dio[2:0];                          // RULE_20
          cmd_ff <= rbcd_pkg::RBCD_CMD_SKIP;
        end
        default:
          cmd_ff <= rbcd_pkg::RBCD_CMD_SKIP;
      endcase
      end
      // Last byte with EOI still executes, then ends the line
      if (line_end)
        cmd_ff <= rbcd_pkg::RBCD_CMD_IDLE;                 // RULE_16
    end
  end

  // ----------------------------------------
  // Reading buffer
  // ----------------------------------------
  logic tx_done;
  logic buf_fill;
  assign tx_done  = (tx_st_ff == 2'h3) && ndac_n_i && tx_idx_ff == `RBCD_RESP_LAST;
  assign buf_fill = tick && (conv_pend_ff || conv_vld_i) && !buf_full_ff && tx_st_ff == 2'h0;

  // Fill consumes the pending result, so a stale value never reloads
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      conv_pend_ff <= 1'b0;
    else if (buf_fill)
      conv_pend_ff <= 1'b0;                                // RULE_11
    else if (conv_vld_i)
      conv_pend_ff <= 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      buf_full_ff <= 1'b0;
      for (int k = 0; k < `RBCD_RESP_LEN; k++)
        resp_ff[k] <= 8'h00;
    end
    else if (tx_done)
    begin
      buf_full_ff <= 1'b0;                                 // RULE_11
    end
    else if (buf_fill)
    begin
      buf_full_ff <= 1'b1;                                 // RULE_12
      resp_ff[0]  <= `RBCD_CH_PLUS;                        // RULE_13
      resp_ff[2]  <= `RBCD_CH_DOT;
      resp_ff[7]  <= `RBCD_CH_E;
      resp_ff[8]  <= conv_exp_neg_i ? `RBCD_CH_MINUS : `RBCD_CH_PLUS;
      resp_ff[9]  <= `RBCD_CH_ZERO | {4'h0, conv_exp_i};
      resp_ff[10] <= `RBCD_CH_CR;                          // RULE_15
      resp_ff[11] <= `RBCD_CH_LF;
      for (int k = 0; k < 5; k++)
      begin
        if (conv_ovr_i)
          resp_ff[k == 0 ? 1 : k + 2] <= (k == 0) ? `RBCD_CH_TWO : `RBCD_CH_ZERO; // RULE_14
        else
          resp_ff[k == 0 ? 1 : k + 2] <= `RBCD_CH_ZERO | {4'h0, conv_dig_i[k]};
      end
    end
  end

  // ----------------------------------------
  // Talker handshake
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      tx_st_ff  <= 2'h0;
      tx_idx_ff <= 4'h0;
    end
    else
    begin
      case (tx_st_ff)
        2'h0:
          if (talk_ff && !atn && buf_full_ff && nrfd_n_i) // RULE_10 RULE_25
            tx_st_ff <= 2'h1;
        2'h1:
          tx_st_ff <= 2'h3;
        2'h3:
          if (ndac_n_i)
          begin
            if (tx_idx_ff == `RBCD_RESP_LAST)
              tx_idx_ff <= 4'h0;
            else
              tx_idx_ff <= tx_idx_ff + 4'h1;
            tx_st_ff <= 2'h2;
          end
        2'h2:
          tx_st_ff <= 2'h0;
        default:
          tx_st_ff <= 2'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      dio_n_o     <= 8'hff;
      dio_oe_n_o  <= 1'b1;
      dav_n_o     <= 1'b1;
      dav_oe_n_o  <= 1'b1;
      eoi_n_o     <= 1'b1;
      eoi_oe_n_o  <= 1'b1;
      nrfd_n_o    <= 1'b1;
      nrfd_oe_n_o <= 1'b1;
      ndac_n_o    <= 1'b1;
      ndac_oe_n_o <= 1'b1;
    end
    else
    begin
      dio_n_o     <= ~resp_ff[tx_idx_ff];
      dio_oe_n_o  <= !(tx_st_ff != 2'h0 && talk_ff);
      dav_n_o     <= !(tx_st_ff == 2'h3);
      dav_oe_n_o  <= !(tx_st_ff == 2'h3);
      eoi_n_o     <= 1'b1;
      eoi_oe_n_o  <= 1'b1;
      nrfd_n_o    <= 1'b0;
      nrfd_oe_n_o <= !(rx_st_ff != 2'h0);
      ndac_n_o    <= 1'b0;
      ndac_oe_n_o <= !(rx_st_ff == 2'h0 && !dav);
    end
  end
endmodule : rbcd_decoder

// [dv/rbcd_ctl_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Bus controller model, open-drain levels
// ----------------------------------------
module rbcd_ctl_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] dio_n_i,
  input  wire logic       dav_n_i,
  input  wire logic       nrfd_n_i,
  input  wire logic       ndac_n_i,
  output logic [7:0]      c_dio_n_o,
  output logic            c_atn_n_o,
  output logic            c_eoi_n_o,
  output logic            c_ren_n_o,
  output logic            c_dav_n_o,
  output logic            c_nrfd_n_o,
  output logic            c_ndac_n_o
);
  wire [2:0] hs = {dav_n_i, nrfd_n_i, ndac_n_i};

  initial
  begin
    c_dio_n_o = 8'hff;
    {c_atn_n_o, c_eoi_n_o, c_ren_n_o, c_dav_n_o, c_nrfd_n_o, c_ndac_n_o} = 6'h3f;
  end

  // Bounded wait for a handshake level
  task automatic wt(int k, logic v);
    int n;
    n = 0;
    do @(posedge clk_sys_i); while (hs[k] !== v && ++n < 3000);
    #1;
  endtask : wt

  task automatic put(logic [7:0] b, logic a, logic e);
    @(posedge clk_sys_i) #1;
    c_nrfd_n_o = 1'b1;
    c_ndac_n_o = 1'b1;
    c_dio_n_o  = ~b;
    c_atn_n_o  = ~a;
    c_eoi_n_o  = ~e;
    wt(1, 1'b1);
    c_dav_n_o = 1'b0;
    wt(0, 1'b1);
    c_dav_n_o = 1'b1;
    c_dio_n_o = 8'hff;
    c_eoi_n_o = 1'b1;
  endtask : put

  task automatic get(output logic [7:0] b);
    @(posedge clk_sys_i) #1;
    c_atn_n_o  = 1'b1;
    c_ndac_n_o = 1'b0;
    c_nrfd_n_o = 1'b1;
    wt(2, 1'b0);
    b = ~dio_n_i;
    c_nrfd_n_o = 1'b0;
    c_ndac_n_o = 1'b1;
    wt(2, 1'b1);
    c_ndac_n_o = 1'b0;
  endtask : get
endmodule : rbcd_ctl_model

// [dv/rbcd_decoder_sva.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module rbcd_decoder_sva (
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  input wire logic [4:0] addr_sw_i,
  input wire logic       ren_n_i,
  input wire logic       dav_n_i,
  input wire logic       ndac_n_i,
  input wire logic [7:0] dio_n_o,
  input wire logic       dio_oe_n_o,
  input wire logic       eoi_oe_n_o,
  input wire logic       dav_oe_n_o,
  input wire logic       ndac_oe_n_o,
  input wire logic       remote_led_o,
  input wire logic       panel_en_o,
  input wire logic [1:0] vrange_o,
  input wire logic [2:0] irange_o,
  input wire logic [4:0] bus_addr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_addr_val;
    $past(resetn_i) && !$past(resetn_i, 2) |-> bus_addr_o == $past(addr_sw_i);
  endproperty
  a_addr_val: assert property (p_addr_val)
    else $error("address not taken from switches");
  property p_addr_hold;
    $past(resetn_i, 2) |-> $stable(bus_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address changed while running");
  property p_start_local;
    $rose(resetn_i) |-> !remote_led_o;
  endproperty
  a_start_local: assert property (p_start_local)
    else $error("not local after reset");
  property p_local_keep;
    !remote_led_o && !$past(remote_led_o) |-> $stable({vrange_o, irange_o});
  endproperty
  a_local_keep: assert property (p_local_keep)
    else $error("range changed in local");
  property p_rem_entry;
    $rose(remote_led_o) |-> !$past(ren_n_i);
  endproperty
  a_rem_entry: assert property (p_rem_entry)
    else $error("remote without REN");
  property p_lamp;
    remote_led_o != panel_en_o;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp and panel disagree");
  property p_dat_stable;
    !dav_oe_n_o && $past(!dav_oe_n_o) |-> $stable(dio_n_o) && !dio_oe_n_o;
  endproperty
  a_dat_stable: assert property (p_dat_stable)
    else $error("data moved under DAV");
  property p_eoi;
    eoi_oe_n_o;
  endproperty
  a_eoi: assert property (p_eoi)
    else $error("EOI driven");
  property p_rng;
    vrange_o <= 2'h2 && irange_o <= 3'h5;
  endproperty
  a_rng: assert property (p_rng)
    else $error("range code out of set");
  property p_ndac;
    $fell(dav_n_i) && dav_oe_n_o |-> ##[1:3] ndac_oe_n_o;
  endproperty
  a_ndac: assert property (p_ndac)
    else $error("NDAC not released");
  property p_dav_hold;
    !dav_oe_n_o && !ndac_n_i |=> !dav_oe_n_o;
  endproperty
  a_dav_hold: assert property (p_dav_hold)
    else $error("DAV dropped early");

  c_remote: cover property ($rose(remote_led_o));
  c_talk:   cover property ($fell(dav_oe_n_o));
  c_v2:     cover property (vrange_o == 2'h2);
  c_i5:     cover property (irange_o == 3'h5);
endmodule : rbcd_decoder_sva

// [dv/rbcd_decoder_tb.sv]
`timescale 1ns/100ps
`include "rbcd_map.svh"
// ----------------------------------------
// Bench
// ----------------------------------------
module rbcd_decoder_tb;
  localparam int SIM_HZ = 2500;
  localparam int TICK   = SIM_HZ * 1000 / `RBCD_RATE_MRPS;
  logic       clk_sys_i, resetn_i, conv_vld_i, conv_ovr_i, conv_exp_neg_i;
  logic [4:0] addr_sw_i, bus_addr_o;
  logic [3:0] conv_dig_i [5];
  logic [3:0] conv_exp_i;
  logic [7:0] dio_n_o, c_dio_n_o, x;
  logic       dio_oe_n_o, eoi_n_o, eoi_oe_n_o, dav_n_o, dav_oe_n_o, nrfd_n_o;
  logic       nrfd_oe_n_o, ndac_n_o, ndac_oe_n_o, remote_led_o, panel_en_o;
  logic       c_atn_n_o, c_eoi_n_o, c_ren_n_o, c_dav_n_o, c_nrfd_n_o, c_ndac_n_o;
  logic [1:0] vrange_o;
  logic [2:0] irange_o;
  wire  [7:0] dio_n_i  = (dio_oe_n_o ? 8'hff : dio_n_o) & c_dio_n_o;
  wire        dav_n_i  = (dav_oe_n_o | dav_n_o) & c_dav_n_o;
  wire        nrfd_n_i = (nrfd_oe_n_o | nrfd_n_o) & c_nrfd_n_o;
  wire        ndac_n_i = (ndac_oe_n_o | ndac_n_o) & c_ndac_n_o;
  wire        eoi_n_i  = (eoi_oe_n_o | eoi_n_o) & c_eoi_n_o;
  wire        atn_n_i  = c_atn_n_o;
  wire        ren_n_i  = c_ren_n_o;
  int         err_count, n_checks, er, ev, ei, ea, cyc;
  int         t [2];
  logic [31:0] rs = 32'haef9;
  logic [7:0] q [$];

  rbcd_decoder #(.CLK_HZ(SIM_HZ)) u_dut (.*);
  rbcd_ctl_model u_ctl (.*);

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs

  task automatic fail(string m);
    err_count++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail

  task automatic chk_st();
    repeat (3) @(posedge clk_sys_i);
    #1;
    n_checks++;
    if ({remote_led_o, panel_en_o, vrange_o, irange_o, bus_addr_o} !==
        {er[0], !er[0], ev[1:0], ei[2:0], ea[4:0]}) fail("state");
  endtask : chk_st

  task automatic chk_rd(logic [7:0] g, logic [7:0] e);
    n_checks++;
    if (g !== e) fail("reading byte");
  endtask : chk_rd

  task automatic cmd(string s, bit eo);
    for (int i = 0; i < s.len(); i++) u_ctl.put(s[i], 1'b0, eo && i == s.len() - 1);
    if (!eo) u_ctl.put(`RBCD_CH_CR, 1'b0, 1'b0);
  endtask : cmd

  task automatic rd(int j);
    @(posedge clk_sys_i) #1;
    conv_ovr_i     = j[0];
    conv_exp_neg_i = xs() & 1;
    conv_exp_i     = 4'(xs() % 10);
    q.push_back("+");
    for (int i = 0; i < 5; i++)
    begin
      conv_dig_i[i] = 4'(xs() % 10);
      q.push_back(j ? (i == 0 ? "2" : "0") : 8'h30 + conv_dig_i[i]);
      if (i == 0) q.push_back(".");
    end
    q.push_back("E");
    q.push_back(conv_exp_neg_i ? "-" : "+");
    q.push_back(8'h30 + conv_exp_i);
    q.push_back(`RBCD_CH_CR);
    q.push_back(`RBCD_CH_LF);
    conv_vld_i = 1'b1;
    @(posedge clk_sys_i) #1 conv_vld_i = 1'b0;
    for (int b = 0; b < 12; b++)
    begin
      u_ctl.get(x);
      if (b == 0) t[j] = cyc;
      chk_rd(x, q.pop_front());
    end
  endtask : rd

  task automatic stop_test();
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) cyc <= cyc + 1;

  initial
  begin
    repeat (30 * TICK) @(posedge clk_sys_i);
    fail("timeout");
    stop_test();
  end

  initial
  begin
    {resetn_i, conv_vld_i, conv_ovr_i, conv_exp_neg_i, conv_exp_i} = '0;
    foreach (conv_dig_i[i]) conv_dig_i[i] = 4'h0;
    ea = xs() % 30 + 1;
    addr_sw_i = ea[4:0];
    repeat (10) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    chk_st();
    addr_sw_i = ~ea[4:0];
    u_ctl.put(8'h20 | ea[4:0], 1'b1, 1'b0);
    cmd("V2", 1'b0);
    chk_st();
    u_ctl.c_ren_n_o = 1'b0;
    u_ctl.put(8'h20 | ea[4:0], 1'b1, 1'b0);
    er = 1;
    chk_st();
    for (int k = 0; k < 7; k++)
    begin
      cmd($sformatf("V%0d,I%0d", k, k), k[0]);
      if (k < 3) ev = k;
      if (k < 6) ei = k;
      chk_st();
    end
    u_ctl.put({1'b0, `RBCD_MSG_UNL}, 1'b1, 1'b0);
    cmd("V0", 1'b0);
    chk_st();
    u_ctl.put({1'b0, `RBCD_MSG_GTL}, 1'b1, 1'b0);
    chk_st();
    u_ctl.put(8'h20 | ea[4:0], 1'b1, 1'b0);
    u_ctl.put({1'b0, `RBCD_MSG_GTL}, 1'b1, 1'b0);
    er = 0;
    chk_st();
    u_ctl.put(8'h20 | ea[4:0], 1'b1, 1'b0);
    er = 1;
    chk_st();
    cmd("L", 1'b0);
    er = 0;
    chk_st();
    for (int i = 0; i < 2; i++)
    begin
      if (i == 1) u_ctl.put(8'h20 | ea[4:0], 1'b1, 1'b0);
      er = i;
      u_ctl.put({1'b0, `RBCD_MSG_UNL}, 1'b1, 1'b0);
      u_ctl.put(8'h40 | ea[4:0], 1'b1, 1'b0);
      rd(0);
      rd(1);
      n_checks++;
      if (t[1] - t[0] < TICK - 5 || t[1] - t[0] > TICK + 5) fail("rate");
      chk_st();
    end
    stop_test();
  end
endmodule : rbcd_decoder_tb

bind rbcd_decoder rbcd_decoder_sva u_sva (.*);
